//--- rtl/ppvs_pkg.sv
package ppvs_pkg;
  localparam int          PPVS_AW         = 8;
  localparam int          PPVS_DW         = 8;
  localparam int          PPVS_BANKW      = 2;
  localparam logic [2:0]  PPVS_MAX_RETRY  = 3'h4;
  localparam logic [7:0]  CH_PROMPT       = 8'h2A;
  localparam logic [7:0]  CH_RETRY        = 8'h24;
  localparam logic [7:0]  CH_FAIL         = 8'h3F;
  localparam logic [7:0]  CH_CMD_LOAD     = 8'h54;
  localparam logic [7:0]  CH_CMD_PROG     = 8'h50;
  localparam logic [7:0]  CH_CMD_LIST     = 8'h4C;
  localparam logic [7:0]  CH_ZERO         = 8'h30;
  localparam logic [7:0]  CH_CR           = 8'h0D;
  localparam logic [7:0]  CH_SPACE        = 8'h20;
  localparam logic [7:0]  DATA_ALL_ONES   = 8'hFF;
  localparam real         PROG_PULSE_US   = 100.0;
  localparam real         CLK_MHZ         = 10.0;
  localparam int          PROG_PULSE_CYC  = int'(PROG_PULSE_US * CLK_MHZ);
  localparam real         READ_SETTLE_US  = 1.0;
  localparam int          READ_SETTLE_CYC = int'(READ_SETTLE_US * CLK_MHZ);
  localparam logic [15:0] CNT_ONE         = 16'h0001;

  typedef enum logic [4:0] {
    ST_PROMPT   = 5'b00000,
    ST_WAITCMD  = 5'b00001,
    ST_GETBANK  = 5'b00010,
    ST_GETLO    = 5'b00011,
    ST_GETHI    = 5'b00100,
    ST_PWRITE   = 5'b00101,
    ST_PREAD    = 5'b00110,
    ST_PCHECK   = 5'b00111,
    ST_RETRYCH  = 5'b01000,
    ST_ADDROUT  = 5'b01001,
    ST_ADVANCE  = 5'b01010,
    ST_FAIL     = 5'b01011,
    ST_HALT     = 5'b01100,
    ST_LREAD    = 5'b01101,
    ST_LOUT     = 5'b01110,
    ST_LOAD     = 5'b01111,
    ST_EMITWAIT = 5'b10000
  } ppvs_state_t;
endpackage

//--- rtl/ppvs_prom_seq.sv
`timescale 1ns/10ps
`default_nettype none
// Operation
// - After each PROM write the location is read back and compared with the intended data.
// - A mismatch reprograms the same location instead of advancing.
// - At most four reprogram attempts follow the first write, counted per location.
// - Each reprogram attempt sends one dollar sign to the terminal.
// - A failure after the fourth retry aborts the run and sends a question mark.
// - Words of a chosen range in a chosen RAM bank are copied to the same PROM addresses.
// - Program asks for a bank number, then an initial and final address from 0 to 255.
// - The address of each location is sent to the terminal as it is programmed.
// - An asterisk prompt is printed whenever the block is idle and ready for a command.
// - Command letters T, P and L start loading, programming and listing.
// - List reads and outputs the whole PROM or an operator range, before or after programming.
// - With write complement selected every bit of PROM write data is inverted.
// - With read complement selected every bit of PROM read data is inverted.
// - With the read path disabled read data returns as all ones, before any read complement.
module ppvs_prom_seq
  import ppvs_pkg::*;
#(
  parameter int PULSE_CYC  = PROG_PULSE_CYC,
  parameter int SETTLE_CYC = READ_SETTLE_CYC
)(
  input  wire logic                  core_clk,
  input  wire logic                  srst,
  input  wire logic                  ttyRxValid,
  input  wire logic [7:0]            ttyRxData,
  input  wire logic                  ttyTxReady,
  output logic                       ttyTxValid,
  output logic [7:0]                 ttyTxData,
  input  wire logic                  writeComplement,
  input  wire logic                  readComplement,
  input  wire logic                  readEnable,
  output logic [PPVS_BANKW-1:0]      ramBankSelect,
  output logic [PPVS_AW-1:0]         ramAddr,
  input  wire logic [PPVS_DW-1:0]    ramRdData,
  output logic [PPVS_AW-1:0]         promAddr,
  output logic [PPVS_DW-1:0]         promWrData,
  output logic                       promProgPulse,
  output logic                       promReadEn,
  input  wire logic [PPVS_DW-1:0]    promRdData,
  output logic                       loadActive,
  output logic                       progFail,
  output logic                       irq,
  input  wire logic [2:0]            intMask,
  input  wire logic [2:0]            intClear
);
  ppvs_tx_if tx ();

  ppvs_state_t state_r;
  ppvs_state_t retState_r;
  logic [PPVS_AW-1:0]  cur_r;
  logic [PPVS_AW-1:0]  last_r;
  logic [2:0]          retry_r;
  logic [15:0]         cnt_r;
  logic [PPVS_DW-1:0]  rdWord_r;
  logic [PPVS_DW-1:0]  expect_r;
  logic                listMode_r;
  logic [7:0]          emitCh_r;
  logic [2:0]          intStat_r;
  logic [2:0]          intEvent;
  logic [PPVS_DW-1:0]  rdPath;
  logic [7:0]          rxBin;
  logic                rxDigit;
  logic [PPVS_AW-1:0]  numNxt;

  ppvs_tx_char u_tx (
    .core_clk   (core_clk),
    .srst       (srst),
    .tx         (tx),
    .ttyTxReady (ttyTxReady),
    .ttyTxValid (ttyTxValid),
    .ttyTxData  (ttyTxData)
  );

  // Read data path options
  always_comb begin
    rdPath = readEnable ? promRdData : DATA_ALL_ONES;
    if (readComplement) begin
      rdPath = ~rdPath;
    end
  end

  // Decimal digit entry
  assign rxBin   = ttyRxData - CH_ZERO;
  assign rxDigit = ttyRxValid && (rxBin < 8'h0A);
  assign numNxt  = PPVS_AW'((cur_r * 8'h0A) + rxBin);

  // Character emitted in the current state
  always_comb begin
    tx.valid = 1'b0;
    tx.data  = emitCh_r;
    if (state_r == ST_EMITWAIT && !tx.busy) begin
      tx.valid = 1'b1;
    end
  end

  // Main sequencer
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r    <= ST_PROMPT;
      retState_r <= ST_WAITCMD;
      cur_r      <= '0;
      last_r     <= '0;
      cnt_r      <= 16'h0000;
      rdWord_r   <= '0;
      expect_r   <= '0;
      listMode_r <= 1'b0;
      emitCh_r   <= CH_PROMPT;
    end else begin
      case (state_r)
        ST_PROMPT: begin
          emitCh_r   <= CH_PROMPT;
          retState_r <= ST_WAITCMD;
          state_r    <= ST_EMITWAIT;
        end
        ST_WAITCMD: begin
          if (ttyRxValid) begin
            if (ttyRxData == CH_CMD_PROG) begin
              listMode_r <= 1'b0;
              state_r    <= ST_GETBANK;
            end else if (ttyRxData == CH_CMD_LIST) begin
              listMode_r <= 1'b1;
              cur_r      <= '0;
              state_r    <= ST_GETLO;
            end else if (ttyRxData == CH_CMD_LOAD) begin
              state_r    <= ST_LOAD;
            end
          end
        end
        ST_LOAD: begin
          if (ttyRxValid && ttyRxData == CH_CR) begin
            state_r    <= ST_PROMPT;
          end
        end
        ST_GETBANK: begin
          if (rxDigit) begin
            cur_r         <= '0;
            state_r       <= ST_GETLO;
          end
        end
        ST_GETLO: begin
          if (rxDigit) begin
            cur_r <= numNxt;
          end else if (ttyRxValid && ttyRxData == CH_SPACE) begin
            last_r  <= cur_r;
            cur_r   <= '0;
            state_r <= ST_GETHI;
          end else if (ttyRxValid && ttyRxData == CH_CR && listMode_r) begin
            cur_r   <= '0;
            last_r  <= '1;
            state_r <= ST_LREAD;
          end
        end
        ST_GETHI: begin
          // last_r temporarily holds the initial address, cur_r the final
          if (rxDigit) begin
            cur_r <= numNxt;
          end
          if (ttyRxValid && ttyRxData == CH_CR) begin
            cur_r   <= last_r;
            last_r  <= cur_r;
            cnt_r   <= 16'h0000;
            state_r <= listMode_r ? ST_LREAD : ST_PWRITE;
          end else if (ttyRxValid && ttyRxData == CH_SPACE) begin
            cur_r <= '0;
          end
        end
        ST_PWRITE: begin
          expect_r <= ramRdData;
          if (cnt_r == 16'(PULSE_CYC)) begin
            cnt_r   <= 16'h0000;
            state_r <= ST_PREAD;
          end else begin
            cnt_r <= cnt_r + CNT_ONE;
          end
        end
        ST_PREAD: begin
          if (cnt_r == 16'(SETTLE_CYC)) begin
            cnt_r    <= 16'h0000;
            rdWord_r <= rdPath;
            state_r  <= ST_PCHECK;
          end else begin
            cnt_r <= cnt_r + CNT_ONE;
          end
        end
        ST_PCHECK: begin
          if (rdWord_r == expect_r) begin
            emitCh_r   <= cur_r;
            retState_r <= ST_ADVANCE;
            state_r    <= ST_EMITWAIT;
          end else if (retry_r == PPVS_MAX_RETRY) begin
            state_r <= ST_FAIL;
          end else begin
            emitCh_r   <= CH_RETRY;
            retState_r <= ST_PWRITE;
            state_r    <= ST_EMITWAIT;
          end
        end
        ST_ADVANCE: begin
          if (cur_r == last_r) begin
            state_r <= ST_PROMPT;
          end else begin
            cur_r   <= cur_r + PPVS_AW'(1);
            state_r <= ST_PWRITE;
          end
        end
        ST_FAIL: begin
          emitCh_r   <= CH_FAIL;
          retState_r <= ST_HALT;
          state_r    <= ST_EMITWAIT;
        end
        ST_HALT: begin
          state_r <= ST_HALT;
        end
        ST_LREAD: begin
          if (cnt_r == 16'(SETTLE_CYC)) begin
            cnt_r    <= 16'h0000;
            emitCh_r <= rdPath;
            state_r  <= ST_LOUT;
          end else begin
            cnt_r <= cnt_r + CNT_ONE;
          end
        end
        ST_LOUT: begin
          retState_r <= (cur_r == last_r) ? ST_PROMPT : ST_ADDROUT;
          state_r    <= ST_EMITWAIT;
        end
        ST_ADDROUT: begin
          cur_r   <= cur_r + PPVS_AW'(1);
          state_r <= ST_LREAD;
        end
        ST_EMITWAIT: begin
          if (!tx.busy) begin
            state_r <= retState_r;
          end
        end
        default: begin
          state_r <= ST_PROMPT;
        end
      endcase
    end
  end

  // PROM and RAM drive
  always_ff @(posedge core_clk) begin
    if (srst) begin
      promAddr      <= '0;
      ramAddr       <= '0;
      promWrData    <= '0;
      promProgPulse <= 1'b0;
      promReadEn    <= 1'b0;
    end else begin
      promAddr      <= cur_r;
      ramAddr       <= cur_r;
      promWrData    <= writeComplement ? ~ramRdData : ramRdData;
      // Pulse starts a cycle late so address and write data are settled under it
      promProgPulse <= (state_r == ST_PWRITE) && (cnt_r != 16'h0000);
      promReadEn    <= (state_r == ST_PREAD) || (state_r == ST_LREAD);
    end
  end

  // RAM bank chosen by the digit after the program command
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ramBankSelect <= '0;
    end else if (state_r == ST_GETBANK && rxDigit) begin
      ramBankSelect <= PPVS_BANKW'(rxBin);
    end
  end

  // Per-location retry count; restarts for every new address
  always_ff @(posedge core_clk) begin
    if (srst) begin
      retry_r <= 3'h0;
    end else if (state_r == ST_ADVANCE) begin
      retry_r <= 3'h0;
    end else if (state_r == ST_GETHI && ttyRxValid && ttyRxData == CH_CR) begin
      retry_r <= 3'h0;
    end else if (state_r == ST_PCHECK && rdWord_r != expect_r
                 && retry_r != PPVS_MAX_RETRY) begin
      retry_r <= retry_r + 3'h1;
    end
  end

  // Load mode flag and failure flag; failure holds until reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      loadActive <= 1'b0;
      progFail   <= 1'b0;
    end else begin
      if (state_r == ST_WAITCMD && ttyRxValid && ttyRxData == CH_CMD_LOAD) begin
        loadActive <= 1'b1;
      end else if (state_r == ST_LOAD && ttyRxValid && ttyRxData == CH_CR) begin
        loadActive <= 1'b0;
      end
      if (state_r == ST_FAIL) begin
        progFail <= 1'b1;
      end
    end
  end

  // Event strobes: 0 retry, 1 failure, 2 run done
  always_comb begin
    intEvent[0] = (state_r == ST_PCHECK) && (rdWord_r != expect_r)
                  && (retry_r != PPVS_MAX_RETRY);
    intEvent[1] = (state_r == ST_FAIL);
    intEvent[2] = (state_r == ST_ADVANCE) && (cur_r == last_r) && !listMode_r;
  end

  // Sticky status bits, write one to clear; an event in the clear cycle wins
  for (genvar gi = 0; gi < $bits(intStat_r); gi++) begin : gStat
    always_ff @(posedge core_clk) begin
      if (srst) begin
        intStat_r[gi] <= 1'b0;
      end else if (intEvent[gi]) begin
        intStat_r[gi] <= 1'b1;
      end else if (intClear[gi]) begin
        intStat_r[gi] <= 1'b0;
      end
    end
  end

  // Level interrupt while any unmasked status bit is set
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(intStat_r & intMask);
    end
  end
endmodule
`default_nettype wire

//--- rtl/ppvs_tx_char.sv
`timescale 1ns/10ps
`default_nettype none
module ppvs_tx_char
  import ppvs_pkg::*;
(
  input  wire logic   core_clk,
  input  wire logic   srst,
  ppvs_tx_if.snk      tx,
  input  wire logic   ttyTxReady,
  output logic        ttyTxValid,
  output logic [7:0]  ttyTxData
);
  // One-character holding stage toward the terminal
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ttyTxValid <= 1'b0;
      ttyTxData  <= 8'h00;
    end else if (tx.valid && !ttyTxValid) begin
      ttyTxValid <= 1'b1;
      ttyTxData  <= tx.data;
    end else if (ttyTxValid && ttyTxReady) begin
      ttyTxValid <= 1'b0;
    end
  end

  assign tx.busy = ttyTxValid;
endmodule
`default_nettype wire

//--- rtl/ppvs_tx_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ppvs_tx_if;
  logic       valid;
  logic [7:0] data;
  logic       busy;
  modport src (output valid, output data, input busy);
  modport snk (input valid, input data, output busy);
endinterface
`default_nettype wire

//--- test/ppvs_prom_model.sv
`timescale 1ns/10ps
`default_nettype none
module ppvs_prom_model
  import ppvs_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic [PPVS_BANKW-1:0] ramBankSelect,
  input  wire logic [PPVS_AW-1:0]    ramAddr,
  output logic [PPVS_DW-1:0]         ramRdData,
  input  wire logic [PPVS_AW-1:0]    promAddr,
  input  wire logic [PPVS_DW-1:0]    promWrData,
  input  wire logic                  promProgPulse,
  input  wire logic                  promReadEn,
  output logic [PPVS_DW-1:0]         promRdData,
  input  wire logic [PPVS_AW-1:0]    failAddr,
  input  wire logic [2:0]            failTimes
);
  logic [7:0] mem [256];
  logic [7:0] lastRd;
  logic [7:0] lastAddr;
  logic [2:0] nFail;
  logic       pulseQ;
  // Word made from the bank and the low six address bits
  assign ramRdData = {ramBankSelect, ramAddr[5:0]} ^ 8'hA5;
  // Deselected lines show the inverse of the last word read
  assign promRdData = promReadEn ? mem[promAddr] : ~lastRd;
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    lastRd = 8'h00;
    lastAddr = 8'hFF;
    nFail = 3'h0;
    pulseQ = 1'b0;
  end
  // Weak cells keep the opposite value for failTimes pulses per location
  always @(posedge core_clk) begin
    pulseQ <= promProgPulse;
    if (promReadEn) lastRd <= mem[promAddr];
    if (promProgPulse && !pulseQ) begin
      lastAddr <= promAddr;
      nFail <= (promAddr == lastAddr) ? nFail + 3'h1 : 3'h1;
      if (promAddr >= failAddr && ((promAddr == lastAddr) ? nFail : 3'h0) < failTimes)
        mem[promAddr] <= ~promWrData;
      else
        mem[promAddr] <= promWrData;
    end
  end
endmodule
`default_nettype wire

//--- test/ppvs_prom_seq_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module ppvs_prom_seq_asserts
  import ppvs_pkg::*;
#(
  parameter int PULSE_CYC = PROG_PULSE_CYC
)(
  input  wire logic               core_clk,
  input  wire logic               srst,
  input  wire logic               ttyTxReady,
  input  wire logic               ttyTxValid,
  input  wire logic [7:0]         ttyTxData,
  input  wire logic [PPVS_AW-1:0] promAddr,
  input  wire logic [PPVS_DW-1:0] promWrData,
  input  wire logic               promProgPulse,
  input  wire logic               promReadEn,
  input  wire logic               progFail,
  input  wire logic               irq,
  input  wire logic [2:0]         intMask
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [15:0] pulseCnt_r;
  // Length of the current programming pulse
  always_ff @(posedge core_clk) begin
    if (srst || !promProgPulse) pulseCnt_r <= 16'h0000;
    else pulseCnt_r <= pulseCnt_r + CNT_ONE;
  end
  sequence sPulseEnd;
    $fell(promProgPulse);
  endsequence
  sequence sReadBack;
    ##[0:2] promReadEn;
  endsequence
  a_pulse_len: assert property (sPulseEnd |-> pulseCnt_r == PULSE_CYC)
    else $error("programming pulse length wrong");
  a_verify_read: assert property (sPulseEnd |-> sReadBack)
    else $error("no read-back after programming pulse");
  a_no_overlap: assert property (!(promProgPulse && promReadEn))
    else $error("read during programming pulse");
  a_write_hold: assert property (promProgPulse && $past(promProgPulse)
    |-> $stable(promAddr) && $stable(promWrData))
    else $error("PROM address or data moved in pulse");
  a_tx_hold: assert property (ttyTxValid && !ttyTxReady
    |=> ttyTxValid && $stable(ttyTxData))
    else $error("terminal character dropped");
  a_fail_sticky: assert property (progFail |=> progFail)
    else $error("failure flag cleared without reset");
  a_fail_halt: assert property (progFail |-> !promProgPulse)
    else $error("programming after abort");
  a_fail_char: assert property (progFail && ttyTxValid |-> ttyTxData == CH_FAIL)
    else $error("wrong character after abort");
  a_irq_masked: assert property ($past(intMask) == 3'h0 |-> !irq)
    else $error("interrupt with all sources masked");
endmodule
bind ppvs_prom_seq ppvs_prom_seq_asserts #(.PULSE_CYC(PULSE_CYC)) uChk (
  .core_clk, .srst, .ttyTxReady, .ttyTxValid, .ttyTxData, .promAddr, .promWrData,
  .promProgPulse, .promReadEn, .progFail, .irq, .intMask);
`default_nettype wire

//--- test/tb_ppvs_prom_seq.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, got, exp) begin nChecks++; if ((got) !== (exp)) begin errors++; \
  $display("mismatch %s exp %h got %h", nm, exp, got); end end
module tb_ppvs_prom_seq
  import ppvs_pkg::*;
();
  logic       core_clk, srst, ttyRxValid, ttyTxValid, promProgPulse;
  logic       ttyTxReady = 1'b0;
  logic       promReadEn, loadActive, progFail, irq;
  logic       writeComplement, readComplement, readEnable;
  logic [7:0] ttyRxData, ttyTxData, ramAddr, ramRdData, promAddr, promWrData;
  logic [7:0] promRdData, failAddr;
  logic [1:0] ramBankSelect;
  logic [2:0] intMask, intClear, failTimes;
  logic [7:0] rxq [$];
  int         errors, nChecks, cyc;
  ppvs_prom_seq #(.PULSE_CYC(4), .SETTLE_CYC(2)) DUT (.core_clk, .srst, .ttyRxValid,
    .ttyRxData, .ttyTxReady, .ttyTxValid, .ttyTxData, .writeComplement, .readComplement,
    .readEnable, .ramBankSelect, .ramAddr, .ramRdData, .promAddr, .promWrData,
    .promProgPulse, .promReadEn, .promRdData, .loadActive, .progFail, .irq, .intMask,
    .intClear);
  ppvs_prom_model PROM (.core_clk, .ramBankSelect, .ramAddr, .ramRdData, .promAddr,
    .promWrData, .promProgPulse, .promReadEn, .promRdData, .failAddr, .failTimes);
  function automatic logic [7:0] ramVal(input logic [1:0] b, input logic [7:0] a);
    return {b, a[5:0]} ^ 8'hA5;
  endfunction
  task automatic closeOut();
    $display("checks %0d mismatches %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic sendStr(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge core_clk);
      ttyRxValid <= 1'b1;
      ttyRxData <= s[i];
      @(posedge core_clk);
      ttyRxValid <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
  endtask
  task automatic expectCh(input logic [7:0] e);
    logic [7:0] c;
    int         w;
    c = 8'hxx;
    w = 0;
    while (rxq.size() == 0 && w < 3000) begin
      @(posedge core_clk);
      w++;
    end
    if (rxq.size() != 0) c = rxq.pop_front();
    `CHK("tty char", c, e)
  endtask
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    ttyTxReady <= ~ttyTxReady;
    if (ttyTxValid === 1'b1 && ttyTxReady) rxq.push_back(ttyTxData);
    cyc++;
    if (cyc == 30000) begin
      errors++;
      closeOut();
    end
  end
  initial begin
    {srst, ttyRxValid, writeComplement, readComplement} = 4'h8;
    {readEnable, ttyRxData, intMask, intClear} = 15'h4000;
    failAddr = 8'hFF;
    failTimes = 3'h0;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    expectCh(CH_PROMPT);
    failAddr <= 8'h06;
    failTimes <= 3'h4;
    sendStr("P15 7\r");
    for (int a = 5; a < 8; a++) begin
      if (a > 5) repeat (4) expectCh(CH_RETRY);
      expectCh(a[7:0]);
      `CHK("prom word", PROM.mem[a], ramVal(2'h1, a[7:0]))
    end
    expectCh(CH_PROMPT);
    `CHK("irq masked", irq, 1'b0)
    intMask <= 3'h4;
    repeat (3) @(posedge core_clk);
    `CHK("irq raised", irq, 1'b1)
    intClear <= 3'h7;
    @(posedge core_clk);
    intClear <= 3'h0;
    repeat (3) @(posedge core_clk);
    `CHK("irq cleared", irq, 1'b0)
    $display("test retry done");
    for (int k = 0; k < 2; k++) begin
      readComplement <= k[0];
      sendStr("L5 7\r");
      for (int a = 5; a < 8; a++) expectCh(ramVal(2'h1, a[7:0]) ^ {8{k[0]}});
      expectCh(CH_PROMPT);
    end
    readComplement <= 1'b0;
    readEnable <= 1'b0;
    sendStr("L\r");
    repeat (256) expectCh(DATA_ALL_ONES);
    expectCh(CH_PROMPT);
    $display("test list done");
    {readEnable, writeComplement, readComplement} <= 3'h7;
    failTimes <= 3'h0;
    sendStr("P29 9\r");
    expectCh(8'h09);
    expectCh(CH_PROMPT);
    `CHK("cpl word", PROM.mem[9], ~ramVal(2'h2, 8'h09))
    {writeComplement, readComplement} <= 2'h0;
    sendStr("T");
    `CHK("load mode", loadActive, 1'b1)
    sendStr("\r");
    expectCh(CH_PROMPT);
    `CHK("load end", loadActive, 1'b0)
    $display("test option done");
    failAddr <= 8'h03;
    failTimes <= 3'h5;
    sendStr("P02 3\r");
    expectCh(8'h02);
    repeat (4) expectCh(CH_RETRY);
    expectCh(CH_FAIL);
    `CHK("fail flag", progFail, 1'b1)
    sendStr("L\r");
    repeat (200) @(posedge core_clk);
    `CHK("quiet count", rxq.size(), 0)
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    expectCh(CH_PROMPT);
    `CHK("fail reset", progFail, 1'b0)
    $display("test abort done");
    closeOut();
  end
endmodule
`default_nettype wire
